// >>> verilog/htqm_defs.svh
`ifndef HTQM_DEFS_SVH
`define HTQM_DEFS_SVH
// register byte offsets on the host port
`define HTQM_OFS_TXCTRL 9'h170
`define HTQM_OFS_STATUS 9'h172
`define HTQM_OFS_FREE 9'h178
`define HTQM_OFS_QCMD 9'h180
`define HTQM_OFS_DATA 9'h1c0
// field positions
`define HTQM_CRC_BIT 1
`define HTQM_IC_BIT 15
`define HTQM_LEN_MSB 10
`define HTQM_ST_REFUSED 15
`define HTQM_ST_MOVING 14
`define HTQM_ST_DONE 13
// reset values and sizes
`define HTQM_TXCTRL_RST 16'h0000
`define HTQM_TX_BYTES 6144
`define HTQM_RX_BYTES 12288
`endif

// >>> verilog/htqm_pkg.sv
package htqm_pkg;
  // transmit drain sequence
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEN = 2'b01,
    ST_DATA = 2'b10,
    ST_PAD = 2'b11
  } htqm_state_t;
endpackage

// >>> verilog/htqm_queue.sv
`timescale 1ns/1ps
`include "htqm_defs.svh"
// What this block does
// (RULE1) 12 KB receive and 6 KB transmit buffers
// (RULE2) entry: control word, byte count, then data
// (RULE3) host keeps frame data at 2000 bytes
// (RULE4) host swaps header bytes when big-endian
// (RULE5) bit 1 of control enables appended CRC
// (RULE6) frames queue back to back, no blocking; code holds one frame, drops staging writes while the queue bit is set
// (RULE7) status shows frame now on the MAC
// (RULE8) host writes one control word per frame
// (RULE9) completion interrupt when control bit 15 set
// (RULE10) frame ident reported with its status
// (RULE11) length bits 10..0 size the allocation
// (RULE12) host never writes a zero byte count
// (RULE13) source address sent as written
// (RULE14) length/type field passed as plain data
// (RULE15) queue command bit clears after transmission
// (RULE16) free transmit space readable in bytes
// (RULE17) host pads data to double-word boundary
// (RULE18) reserved header bits written zero, ignored
// (RULE19) entries larger than free space refused
module htqm_queue #(
  parameter int TX_BYTES = `HTQM_TX_BYTES, // transmit buffer size
  parameter int RX_BYTES = `HTQM_RX_BYTES // receive buffer size
) (
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset
  input wire logic ce, // clock enable
  input wire logic [8:0] host_addr, // register byte offset
  input wire logic host_wr, // register write strobe
  input wire logic host_rd, // register read strobe
  input wire logic [15:0] host_wdata, // write data
  output logic [15:0] host_rdata, // read data, next cycle
  output logic mac_valid, // transmit word valid
  input wire logic mac_ready, // mac takes word
  output logic [15:0] mac_data, // transmit word
  output logic [1:0] mac_be, // valid bytes of word
  output logic mac_last, // last word of frame
  output logic mac_crc_en, // mac appends crc
  input wire logic mac_rx_valid, // receive word valid
  output logic mac_rx_ready, // receive buffer has room
  input wire logic [15:0] mac_rx_data, // receive word
  output logic tx_irq // frame complete interrupt pulse
);
  // ----------------------------------------------------------
  // sizes and state
  // ----------------------------------------------------------
  localparam int TXW = TX_BYTES / 2; // transmit words
  localparam int RXW = RX_BYTES / 2; // receive words
  localparam int TPW = $clog2(TXW); // transmit pointer width
  localparam int RPW = $clog2(RXW); // receive pointer width
  localparam int UW = $clog2(TX_BYTES + 1); // byte count width
  localparam logic [TPW+1:0] TXW_L = (TPW+2)'(TXW);
  localparam logic [UW-1:0] TXB_L = UW'(TX_BYTES);
  localparam logic [RPW-1:0] RXLAST = RPW'(RXW - 1);
  localparam logic [RPW:0] RXW_L = (RPW+1)'(RXW);

  typedef struct packed {
    htqm_pkg::htqm_state_t st; // drain state
    logic [15:0] txctl; // transmit control register
    logic qbusy; // queue command bit
    logic [TPW-1:0] cm_ptr; // end of committed entries
    logic [TPW-1:0] rd_ptr; // drain read pointer
    logic [TPW:0] stg_words; // words staged by host
    logic [10:0] stg_len; // staged byte count
    logic stg_bad; // staged entry overflowed
    logic [UW-1:0] used; // committed bytes
    logic ic; // interrupt on completion
    logic [10:0] flen; // length of draining frame
    logic [10:0] rem; // bytes left to send
    logic pad; // pad word follows data
    logic [15:0] status; // transmit frame status
    logic [RPW-1:0] rx_wp; // receive write pointer
    logic [RPW-1:0] rx_rp; // receive read pointer
    logic [RPW:0] rx_cnt; // receive words held
    logic [15:0] rdata; // read data
    logic irq; // interrupt pulse
  } htqm_regs_t;

  htqm_regs_t r; // registered state
  htqm_regs_t n; // next state
  logic [15:0] tx_mem [TXW]; // transmit packet buffer
  logic [15:0] rx_mem [RXW]; // receive packet buffer
  logic wr_ok; // staged word accepted
  logic rx_push; // receive word taken
  logic [TPW-1:0] wr_addr; // staging write address

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  // advance a transmit pointer with wrap
  function automatic logic [TPW-1:0] tadv(
    input logic [TPW-1:0] p,
    input logic [TPW:0] k
  );
    logic [TPW+1:0] s;
    s = {2'b00, p} + {1'b0, k};
    if (s >= TXW_L)
    begin
      s = s - TXW_L;
    end
    return s[TPW-1:0];
  endfunction

  // bytes taken by an entry of a given length
  function automatic logic [UW-1:0] ebytes(input logic [10:0] len);
    logic [12:0] x;
    x = {2'b00, len} + 13'h3;
    x = {x[12:2], 2'b00} + 13'h4;
    return UW'(x);
  endfunction

  // ----------------------------------------------------------
  // ports
  // ----------------------------------------------------------
  assign wr_addr = tadv(r.cm_ptr, r.stg_words);
  // words past the free space are dropped, not written
  assign wr_ok = host_wr && host_addr == `HTQM_OFS_DATA && !r.qbusy
    && ({1'b0, r.used} + {r.stg_words[UW-2:0], 1'b0} + (UW+1)'(2))
    <= {1'b0, TXB_L}; // RULE19
  assign mac_rx_ready = ce && r.rx_cnt != RXW_L; // RULE6
  assign rx_push = mac_rx_valid && mac_rx_ready;
  assign mac_valid = ce && r.st == htqm_pkg::ST_DATA;
  assign mac_data = tx_mem[r.rd_ptr]; // RULE13 RULE14
  assign mac_be = r.rem >= 11'h2 ? 2'b11 : 2'b01;
  assign mac_last = r.rem <= 11'h2;
  assign mac_crc_en = r.txctl[`HTQM_CRC_BIT]; // RULE5
  assign host_rdata = r.rdata;
  assign tx_irq = r.irq;

  // ----------------------------------------------------------
  // buffer memories
  // ----------------------------------------------------------
  // transmit staging writes and receive pushes
  always_ff @(posedge clk)
  begin
    if (ce && wr_ok)
    begin
      tx_mem[wr_addr] <= host_wdata; // RULE2
    end
    if (ce && rx_push)
    begin
      rx_mem[r.rx_wp] <= mac_rx_data; // RULE1
    end
  end

  // ----------------------------------------------------------
  // next state
  // ----------------------------------------------------------
  always_comb
  begin
    logic [UW-1:0] add;
    logic [UW-1:0] sub;
    logic [UW-1:0] eb;
    logic [15:0] w;
    logic pop;
    n = r;
    add = '0;
    sub = '0;
    pop = 1'b0;
    w = tx_mem[r.rd_ptr];
    eb = ebytes(r.stg_len);
    n.irq = 1'b0;
    // host register writes
    if (host_wr)
    begin
      case (host_addr)
        `HTQM_OFS_TXCTRL: n.txctl = host_wdata;
        `HTQM_OFS_QCMD:
        begin
          if (host_wdata[0] && !r.qbusy)
          begin
            // refuse overflowed, empty or oversized entries
            if (r.stg_bad || r.stg_len == 11'h0
                || eb > TXB_L - r.used) // RULE19
            begin
              n.status[`HTQM_ST_REFUSED] = 1'b1;
            end
            else
            begin
              n.qbusy = 1'b1; // RULE15
              n.status[`HTQM_ST_REFUSED] = 1'b0;
              n.cm_ptr = tadv(r.cm_ptr, (TPW+1)'(eb >> 1)); // RULE11
              add = eb; // RULE11
            end
            n.stg_words = '0;
            n.stg_bad = 1'b0;
          end
        end
        `HTQM_OFS_DATA:
        begin
          if (wr_ok)
          begin
            n.stg_words = r.stg_words + (TPW+1)'(1);
            if (r.stg_words == (TPW+1)'(1))
            begin
              n.stg_len = host_wdata[`HTQM_LEN_MSB:0]; // RULE11
            end
          end
          else if (!r.qbusy)
          begin
            n.stg_bad = 1'b1; // RULE19
          end
        end
        default: ;
      endcase
    end
    // host register reads
    if (host_rd)
    begin
      case (host_addr)
        `HTQM_OFS_TXCTRL: n.rdata = r.txctl;
        `HTQM_OFS_STATUS: n.rdata = r.status; // RULE7
        `HTQM_OFS_FREE: n.rdata = 16'(TXB_L - r.used); // RULE16
        `HTQM_OFS_QCMD: n.rdata = {15'h0, r.qbusy};
        `HTQM_OFS_DATA:
        begin
          pop = r.rx_cnt != '0;
          n.rdata = pop ? rx_mem[r.rx_rp] : 16'h0;
        end
        default: n.rdata = 16'h0;
      endcase
    end
    // receive buffer bookkeeping
    if (rx_push)
    begin
      n.rx_wp = r.rx_wp == RXLAST ? '0 : r.rx_wp + RPW'(1);
    end
    if (pop)
    begin
      n.rx_rp = r.rx_rp == RXLAST ? '0 : r.rx_rp + RPW'(1);
    end
    n.rx_cnt = r.rx_cnt + (RPW+1)'(rx_push) - (RPW+1)'(pop);
    // transmit drain toward the mac
    case (r.st)
      htqm_pkg::ST_IDLE:
      begin
        if (r.used != '0) // RULE6
        begin
          n.ic = w[`HTQM_IC_BIT]; // RULE9
          n.status[5:0] = w[5:0]; // RULE10
          n.status[`HTQM_ST_MOVING] = 1'b1; // RULE7
          n.status[`HTQM_ST_DONE] = 1'b0;
          n.rd_ptr = tadv(r.rd_ptr, (TPW+1)'(1));
          n.st = htqm_pkg::ST_LEN;
        end
      end
      htqm_pkg::ST_LEN:
      begin
        n.flen = w[`HTQM_LEN_MSB:0]; // RULE11
        n.rem = w[`HTQM_LEN_MSB:0];
        n.pad = w[1] ^ w[0]; // pad when ceil(len/2) odd
        n.rd_ptr = tadv(r.rd_ptr, (TPW+1)'(1));
        n.st = htqm_pkg::ST_DATA; // RULE2
      end
      htqm_pkg::ST_DATA:
      begin
        if (mac_ready)
        begin
          n.rd_ptr = tadv(r.rd_ptr, (TPW+1)'(1));
          n.rem = mac_last ? 11'h0 : r.rem - 11'h2;
          if (mac_last)
          begin
            n.st = r.pad ? htqm_pkg::ST_PAD : htqm_pkg::ST_IDLE;
          end
        end
      end
      htqm_pkg::ST_PAD:
      begin
        n.rd_ptr = tadv(r.rd_ptr, (TPW+1)'(1));
        n.st = htqm_pkg::ST_IDLE;
      end
      default: n.st = htqm_pkg::ST_IDLE;
    endcase
    // frame finished: release space, report, interrupt
    if ((r.st == htqm_pkg::ST_DATA && mac_ready && mac_last && !r.pad)
        || r.st == htqm_pkg::ST_PAD)
    begin
      sub = ebytes(r.flen);
      n.irq = r.ic; // RULE9
      n.qbusy = 1'b0; // RULE15
      n.status[`HTQM_ST_MOVING] = 1'b0;
      n.status[`HTQM_ST_DONE] = 1'b1;
    end
    n.used = r.used + add - sub;
  end

  // ----------------------------------------------------------
  // state register
  // ----------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      r <= '0;
      r.txctl <= `HTQM_TXCTRL_RST;
    end
    else if (ce)
    begin
      r <= n;
    end
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  a_used_bound: assert property (@(posedge clk) disable iff (srst) // RULE19
    r.used <= TXB_L) else $error("committed bytes exceed buffer");
  a_free_read: assert property (@(posedge clk) disable iff (srst) // RULE16
    ce && host_rd && host_addr == `HTQM_OFS_FREE |=>
    host_rdata == 16'(TXB_L - $past(r.used)))
    else $error("free space read wrong");
  a_crc_follow: assert property (@(posedge clk) disable iff (srst) // RULE5
    ce && host_wr && host_addr == `HTQM_OFS_TXCTRL |=>
    mac_crc_en == $past(host_wdata[1])) else $error("crc enable lost");
  a_irq_cause: assert property (@(posedge clk) disable iff (srst) // RULE9
    tx_irq |-> $past(r.ic) && $past(r.st) inside
    {htqm_pkg::ST_DATA, htqm_pkg::ST_PAD}) else $error("stray irq");
  a_irq_ident: assert property (@(posedge clk) disable iff (srst) // RULE10
    tx_irq |-> r.status[5:0] == $past(r.status[5:0])
    && r.status[13]) else $error("status ident wrong at irq");
  a_qcmd_clear: assert property (@(posedge clk) disable iff (srst) // RULE15
    $fell(r.qbusy) |-> r.status[13] && !r.status[14])
    else $error("queue bit cleared early");
  a_moving_flag: assert property (@(posedge clk) disable iff (srst) // RULE7
    mac_valid |-> r.status[14] && !r.status[13])
    else $error("status not showing frame");
  a_hdr_order: assert property (@(posedge clk) disable iff (srst) // RULE2
    ce && r.st == htqm_pkg::ST_LEN |=> r.st == htqm_pkg::ST_DATA
    && r.rem == $past(mac_data[10:0])) else $error("header order");
  a_last_len: assert property (@(posedge clk) disable iff (srst) // RULE11
    mac_valid && mac_last |-> r.rem != 11'h0 && r.rem <= 11'h2)
    else $error("last word mismatch");
  a_back2back: assert property (@(posedge clk) disable iff (srst) // RULE6
    ce && r.st == htqm_pkg::ST_IDLE && r.used != '0 |=>
    r.st == htqm_pkg::ST_LEN) else $error("queued frame stalled");
endmodule

// >>> verif/htqm_mac_sink.sv
`timescale 1ns/1ps
// ----------------------------------------
// mac side sink, stalls at random
// ----------------------------------------
module htqm_mac_sink (
  input wire logic clk, // system clock
  input wire logic hold, // stall request from bench
  input wire logic mac_valid, // word offered
  output logic mac_ready, // sink takes word
  input wire logic [15:0] mac_data, // offered word
  input wire logic [1:0] mac_be, // valid bytes
  input wire logic mac_last // final word of frame
);
  logic [15:0] got[$]; // words taken, unused high byte cleared
  int lasts = 0; // final words taken
  initial mac_ready = 1'b0;
  // take a word on handshake, then pick next ready
  always @(posedge clk)
  begin
    if (mac_valid === 1'b1 && mac_ready === 1'b1)
    begin
      if (mac_last === 1'b1)
        lasts++;
      if (mac_be === 2'b01)
        got.push_back({8'h00, mac_data[7:0]});
      else
        got.push_back(mac_data);
    end
    mac_ready <= !hold && ($urandom % 4 != 0);
  end
endmodule

// >>> verif/test_host_transmit_queue_manager.sv
`timescale 1ns/1ps
`include "htqm_defs.svh"
module test_host_transmit_queue_manager;
  localparam int TXB = 64; // small transmit buffer
  localparam int RXW = 32; // small receive buffer, in words
  logic clk, srst, ce, host_wr, host_rd, hold; // bench drives
  logic mac_valid, mac_ready, mac_last, mac_crc_en, tx_irq; // status
  logic mac_rx_valid, mac_rx_ready; // receive handshake
  logic [8:0] host_addr; // register offset
  logic [15:0] host_wdata, host_rdata, mac_data, mac_rx_data; // data
  logic [1:0] mac_be; // byte enables
  logic [15:0] v; // read result
  int bad_count = 0; // mismatches
  int n_compared = 0; // comparisons
  int irq_n = 0; // completion pulses seen
  int lens[6] = '{1, 60, 0, 0, 0, 0}; // frame lengths
  htqm_queue #(.TX_BYTES(TXB), .RX_BYTES(2 * RXW)) uut (.clk(clk), .srst(srst),
    .ce(ce), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
    .host_wdata(host_wdata), .host_rdata(host_rdata),
    .mac_valid(mac_valid), .mac_ready(mac_ready), .mac_data(mac_data),
    .mac_be(mac_be), .mac_last(mac_last), .mac_crc_en(mac_crc_en),
    .mac_rx_valid(mac_rx_valid), .mac_rx_ready(mac_rx_ready),
    .mac_rx_data(mac_rx_data), .tx_irq(tx_irq));
  htqm_mac_sink mac (.clk(clk), .hold(hold), .mac_valid(mac_valid),
    .mac_ready(mac_ready), .mac_data(mac_data), .mac_be(mac_be),
    .mac_last(mac_last));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // count completion pulses
  always @(posedge clk)
    if (tx_irq === 1'b1)
      irq_n++;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    begin
      n_compared++;
      if (seen !== exp)
      begin
        bad_count++;
        $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // one register write, strobe for one edge
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    begin
      host_addr = a;
      host_wdata = d;
      host_wr = 1'b1;
      @(posedge clk);
      #1 host_wr = 1'b0;
      @(posedge clk);
      #1;
    end
  endtask
  // one register read, data taken a cycle later
  task automatic rd(input logic [8:0] a, output logic [15:0] d);
    begin
      host_addr = a;
      host_rd = 1'b1;
      @(posedge clk);
      #1 host_rd = 1'b0;
      @(posedge clk);
      #1 d = host_rdata;
    end
  endtask
  // stage one entry, queue it with the mac stalled, then drain
  task automatic send(input int len, input logic [15:0] ctl);
    logic [15:0] f0, w;
    logic [15:0] exp[$];
    int ent, n0, k, l0;
    begin
      ent = 4 + (len + 3) / 4 * 4;
      mac.got.delete();
      n0 = irq_n;
      l0 = mac.lasts;
      rd(`HTQM_OFS_FREE, f0);
      wr(`HTQM_OFS_DATA, ctl);
      wr(`HTQM_OFS_DATA, 16'(len));
      for (int i = 0; i < ent / 2 - 2; i++)
      begin
        w = 16'($urandom);
        wr(`HTQM_OFS_DATA, w);
        if (2 * i + 1 < len)
          exp.push_back(w);
        else if (2 * i < len)
          exp.push_back({8'h00, w[7:0]});
      end
      hold = 1'b1;
      wr(`HTQM_OFS_QCMD, 16'h0001);
      rd(`HTQM_OFS_QCMD, v);
      if (ent > f0)
      begin
        chk(v, 16'h0000);
        rd(`HTQM_OFS_STATUS, v);
        chk({15'h0, v[15]}, 16'h0001);
        rd(`HTQM_OFS_FREE, v);
        chk(v, f0);
        chk(16'(irq_n - n0), 16'h0000);
        hold = 1'b0;
      end
      else
      begin
        chk(v, 16'h0001);
        rd(`HTQM_OFS_FREE, v);
        chk(v, f0 - 16'(ent));
        rd(`HTQM_OFS_STATUS, v);
        chk({8'h0, v[15:14], v[5:0]}, {10'h1, ctl[5:0]});
        hold = 1'b0;
        k = 0;
        do
        begin
          rd(`HTQM_OFS_QCMD, v);
          k++;
        end
        while (v[0] !== 1'b0 && k < 200);
        chk(v, 16'h0000);
        rd(`HTQM_OFS_STATUS, v);
        chk({9'h0, v[13], v[5:0]}, {10'h1, ctl[5:0]});
        rd(`HTQM_OFS_FREE, v);
        chk(v, f0);
        chk(16'(irq_n - n0), {15'h0, ctl[15]});
        chk(16'(mac.got.size()), 16'(exp.size()));
        chk(16'(mac.lasts - l0), 16'h0001);
        foreach (exp[i])
          chk(mac.got[i], exp[i]);
      end
    end
  endtask
  task automatic tally_and_finish;
    begin
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    #100000;
    bad_count++;
    tally_and_finish;
  end
  initial
  begin
    void'($urandom(32'ha498a124));
    {srst, ce, host_addr, host_wr, host_rd, host_wdata} = {2'b11, 27'h0};
    {mac_rx_valid, mac_rx_data, hold} = 18'h0;
    repeat (3) @(posedge clk);
    #1 srst = 1'b0;
    // reset values and an unmapped offset
    rd(`HTQM_OFS_STATUS, v);
    chk(v, 16'h0000);
    rd(`HTQM_OFS_FREE, v);
    chk(v, 16'(TXB));
    rd(9'h100, v);
    chk(v, 16'h0000);
    $display("test reset done");
    // crc enable follows control bit 1
    for (int b = 1; b >= 0; b--)
    begin
      wr(`HTQM_OFS_TXCTRL, 16'(b * 2));
      chk({15'h0, mac_crc_en}, 16'(b));
      rd(`HTQM_OFS_TXCTRL, v);
      chk(v, 16'(b * 2));
    end
    $display("test crc done");
    // fill the receive buffer back to back, then pop it empty
    for (int i = 0; i < RXW; i++)
    begin
      mac_rx_valid = 1'b1;
      mac_rx_data = 16'h1a00 + 16'(i);
      @(posedge clk);
      #1;
    end
    mac_rx_valid = 1'b0;
    chk({15'h0, mac_rx_ready}, 16'h0000);
    for (int i = 0; i < RXW; i++)
    begin
      rd(`HTQM_OFS_DATA, v);
      chk(v, 16'h1a00 + 16'(i));
    end
    chk({15'h0, mac_rx_ready}, 16'h0001);
    rd(`HTQM_OFS_DATA, v);
    chk(v, 16'h0000);
    $display("test receive done");
    // frames: smallest, buffer full, random
    for (int i = 0; i < 6; i++)
    begin
      if (i > 1)
        lens[i] = 1 + $urandom % 40;
      send(lens[i], {1'($urandom), 9'h000, 6'($urandom)});
    end
    $display("test frames done");
    // entry larger than the buffer is refused
    send(61, 16'h8005);
    $display("test refuse done");
    tally_and_finish;
  end
endmodule
